// [hw/ptr_pkg.sv]
package ptr_pkg;
   // ---------------------------------------------------------------
   // program memory layout
   // ---------------------------------------------------------------
   localparam int PC_W = 11;
   localparam logic [10:0] RESET_VECTOR = 11'h000;
   localparam logic [10:0] EXT_VECTOR = 11'h004;
   localparam logic [10:0] TMR0_VECTOR = 11'h008;
   localparam logic [10:0] TMR1_VECTOR = 11'h00C;
   localparam logic [10:0] ADC_VECTOR = 11'h010;
   localparam logic [10:0] TB_VECTOR = 11'h014;
   localparam logic [2:0] LAST_PAGE = 3'h7;
   localparam int WORD_W = 15;
   localparam int STACK_DEPTH = 6;
   // ---------------------------------------------------------------
   // data memory layout
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_IND0 = 8'h00;
   localparam logic [7:0] ADDR_MP0 = 8'h01;
   localparam logic [7:0] ADDR_TBLP = 8'h07;
   localparam logic [7:0] ADDR_THH = 8'h08;
   localparam logic [7:0] SFR_END = 8'h3F;
   localparam logic [7:0] GP_BASE = 8'h40;
   localparam int GP_DEPTH = 96;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // edge select codes
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic bset;
      logic bclr;
      logic [2:0] bit_sel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ptr_dacc_t;

   typedef struct packed {
      logic ext;
      logic tmr0;
      logic tmr1;
      logic adc;
      logic tb;
   } ptr_irq_t;
endpackage

// [hw/ptr_unit.sv]
`timescale 1ns/10ps
// Summary of operation
// R1: reset loads pc with reset vector
// R2: enabled ext edge vectors when stack free
// R3: ext edge falling, rising or both selectable
// R4: timer overflow vectors to own entry
// R5: conversion done vectors to converter entry
// R6: time base overflow vectors to entry
// R7: table pointer gives low address byte
// R8: current page uses pc high bits
// R9: last page forces high bits to one
// R10: low byte to target, high to holding; code writes low byte only when target is a general purpose location
// R11: unused holding bits read zero
// R12: holding register read only to software
// R13: table instructions take two cycles
// R14: pointer is offset within current page
// R15: data memory eight bits from zero
// R16: general area follows special area directly
// R17: general locations read and write
// R18: protected special locations ignore writes
// R19: bit set clear except dedicated bits
// R20: data memory reachable through pointer
// R21: unused special locations read zero
// R22: indirect port accesses pointed location
// R23: full stack latches request, defers acknowledge
// R24: second table cycle uses program port
module ptr_unit
   import ptr_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // core sequencing
   input wire logic step_i,
   input wire logic tbl_current_i,
   input wire logic tbl_last_i,
   input wire logic [7:0] tbl_dest_i,
   input wire logic ret_i,
   input wire logic call_i,
   input wire logic [10:0] pc_load_i,
   input wire logic pc_load_en_i,
   // program memory word
   input wire logic [14:0] prog_data_i,
   // interrupt sources
   input wire logic ext_pin_i,
   input wire logic [1:0] edge_select_control_i,
   input wire ptr_irq_t irq_en_i,
   input wire logic tmr0_ovf_i,
   input wire logic tmr1_ovf_i,
   input wire logic adc_done_i,
   input wire logic tb_ovf_i,
   // data memory access
   input wire ptr_dacc_t dacc_i,
   // outputs
   output logic [10:0] pc_o,
   output logic [10:0] prog_addr_o,
   output logic tbl_busy_o,
   output logic [7:0] rdata_o,
   output logic [6:0] table_high_holding_o,
   output ptr_irq_t irq_pend_o,
   output logic irq_ack_o
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [7:0] gp_mem [0:GP_DEPTH-1];
   logic [7:0] tbl_ptr_reg;
   logic [7:0] memory_pointer_zero_reg;
   logic [6:0] thh_reg;
   logic [10:0] pc_reg;
   logic [10:0] paddr_reg;
   logic [2:0] sp_reg;
   logic ext_d_reg;
   ptr_irq_t pend_reg;
   logic ack_reg;
   logic [7:0] rdata_reg;
   logic busy_reg;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_TBL = 3'b010,
      ST_FETCH = 3'b100
   } ptr_state_t;
   ptr_state_t state_reg;
   logic tbl_is_last_reg;
   logic [7:0] tbl_dest_reg;

   // ---------------------------------------------------------------
   // address resolution
   // ---------------------------------------------------------------
   logic [7:0] eff_addr;
   logic gp_hit;
   logic [6:0] gp_idx;
   logic stack_full;
   assign eff_addr = (dacc_i.addr == ADDR_IND0) ? memory_pointer_zero_reg : dacc_i.addr; // see R22 R20
   assign gp_hit = (eff_addr >= GP_BASE) && (eff_addr < GP_BASE + 8'(GP_DEPTH)); // see R16
   assign gp_idx = 7'(eff_addr - GP_BASE);
   assign stack_full = (sp_reg == 3'(STACK_DEPTH));

   // table address: high bits from pc page or forced to last page
   logic [10:0] tbl_addr;
   assign tbl_addr = {(tbl_is_last_reg ? LAST_PAGE : pc_reg[10:8]), tbl_ptr_reg}; // see R7 R8 R9 R14

   // ---------------------------------------------------------------
   // edge detection on external pin
   // ---------------------------------------------------------------
   logic ext_edge;
   always_comb
   begin
      case (edge_select_control_i) // see R3
         EDGE_FALL: ext_edge = ext_d_reg & ~ext_pin_i;
         EDGE_RISE: ext_edge = ~ext_d_reg & ext_pin_i;
         EDGE_BOTH: ext_edge = ext_d_reg ^ ext_pin_i;
         default: ext_edge = 1'b0;
      endcase
   end

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         ext_d_reg <= 1'b0;
      else
         ext_d_reg <= ext_pin_i;
   end

   // ---------------------------------------------------------------
   // interrupt request latches; set beats acknowledge clear
   // ---------------------------------------------------------------
   ptr_irq_t raw;
   ptr_irq_t take;
   assign raw = '{ext: ext_edge, tmr0: tmr0_ovf_i, tmr1: tmr1_ovf_i, adc: adc_done_i, tb: tb_ovf_i};
   logic can_ack;
   assign can_ack = (state_reg == ST_RUN) && step_i && !stack_full && !tbl_current_i && !tbl_last_i; // see R23

   // fixed priority: external, timer 0, timer 1, converter, time base
   always_comb
   begin
      take = '0;
      if (can_ack)
      begin
         if (pend_reg.ext) take.ext = 1'b1;
         else if (pend_reg.tmr0) take.tmr0 = 1'b1;
         else if (pend_reg.tmr1) take.tmr1 = 1'b1;
         else if (pend_reg.adc) take.adc = 1'b1;
         else if (pend_reg.tb) take.tb = 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         pend_reg <= '0;
      else
         pend_reg <= ((pend_reg & ~take) | (raw & irq_en_i)); // see R2 R4 R5 R6 R23
   end

   // ---------------------------------------------------------------
   // sequencing: program counter, stack level, table cycles
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_reg <= ST_RUN;
         pc_reg <= RESET_VECTOR; // see R1
         paddr_reg <= RESET_VECTOR;
         sp_reg <= 3'h0;
         ack_reg <= 1'b0;
         tbl_is_last_reg <= 1'b0;
         tbl_dest_reg <= 8'h00;
         busy_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= |take;
         case (state_reg)
            ST_RUN:
            begin
               if (|take)
               begin
                  // vector entry pushes one level
                  sp_reg <= sp_reg + 3'h1;
                  if (take.ext) pc_reg <= EXT_VECTOR; // see R2
                  else if (take.tmr0) pc_reg <= TMR0_VECTOR; // see R4
                  else if (take.tmr1) pc_reg <= TMR1_VECTOR; // see R4
                  else if (take.adc) pc_reg <= ADC_VECTOR; // see R5
                  else pc_reg <= TB_VECTOR; // see R6
                  paddr_reg <= take.ext ? EXT_VECTOR : take.tmr0 ? TMR0_VECTOR : take.tmr1 ? TMR1_VECTOR
                               : take.adc ? ADC_VECTOR : TB_VECTOR;
               end
               else if (step_i && (tbl_current_i || tbl_last_i))
               begin
                  state_reg <= ST_TBL; // see R13
                  busy_reg <= 1'b1;
                  tbl_is_last_reg <= tbl_last_i;
                  tbl_dest_reg <= tbl_dest_i;
               end
               else if (step_i)
               begin
                  if (ret_i && sp_reg != 3'h0)
                     sp_reg <= sp_reg - 3'h1;
                  else if (call_i && !stack_full)
                     sp_reg <= sp_reg + 3'h1;
                  pc_reg <= pc_load_en_i ? pc_load_i : pc_reg + 11'h001;
                  paddr_reg <= pc_load_en_i ? pc_load_i : pc_reg + 11'h001;
               end
            end
            ST_TBL:
            begin
               paddr_reg <= tbl_addr; // see R24
               state_reg <= ST_FETCH;
            end
            ST_FETCH:
            begin
               // instruction fetch resumes after the table word
               paddr_reg <= pc_reg; // see R24 R13
               busy_reg <= 1'b0;
               state_reg <= ST_RUN;
            end
            default:
            begin
               state_reg <= ST_RUN;
               busy_reg <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // special registers: pointer, table pointer, holding register
   // ---------------------------------------------------------------
   // read value is needed by the bit set and clear merge below
   logic [7:0] rd_val;
   logic [7:0] wval;
   always_comb
   begin
      wval = dacc_i.wdata;
      if (dacc_i.bset) wval = rd_val | (8'h01 << dacc_i.bit_sel); // see R19
      if (dacc_i.bclr) wval = rd_val & ~(8'h01 << dacc_i.bit_sel);
   end
   logic do_wr;
   assign do_wr = dacc_i.wr | dacc_i.bset | dacc_i.bclr;

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         memory_pointer_zero_reg <= DATA_RESET;
         tbl_ptr_reg <= DATA_RESET;
         thh_reg <= 7'h00;
      end
      else
      begin
         // holding register changes only by table read; writes dropped
         if (state_reg == ST_FETCH)
            thh_reg <= prog_data_i[14:8]; // see R10 R11 R12 R18
         if (do_wr && eff_addr == ADDR_MP0)
            memory_pointer_zero_reg <= wval;
         if (do_wr && eff_addr == ADDR_TBLP)
            tbl_ptr_reg <= wval;
      end
   end

   // ---------------------------------------------------------------
   // general purpose ram; table low byte lands here too
   // ---------------------------------------------------------------
   logic [7:0] tdest_eff;
   assign tdest_eff = 8'(tbl_dest_reg - GP_BASE);
   always_ff @(posedge clock_i)
   begin
      if (state_reg == ST_FETCH && tbl_dest_reg >= GP_BASE && tbl_dest_reg < GP_BASE + 8'(GP_DEPTH))
         gp_mem[tdest_eff[6:0]] <= prog_data_i[7:0]; // see R10
      else if (do_wr && gp_hit)
         gp_mem[gp_idx] <= wval; // see R17 R15
   end

   // ---------------------------------------------------------------
   // read mux: unused and indirect-through-indirect read zero
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_val = 8'h00; // see R21
      if (gp_hit) rd_val = gp_mem[gp_idx]; // see R17 R20
      else if (eff_addr == ADDR_MP0) rd_val = memory_pointer_zero_reg;
      else if (eff_addr == ADDR_TBLP) rd_val = tbl_ptr_reg;
      else if (eff_addr == ADDR_THH) rd_val = {1'b0, thh_reg}; // see R11
   end

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rdata_reg <= 8'h00;
      else if (dacc_i.rd)
         rdata_reg <= rd_val;
   end

   // outputs from flops
   assign pc_o = pc_reg;
   assign prog_addr_o = paddr_reg;
   assign tbl_busy_o = busy_reg;
   assign rdata_o = rdata_reg;
   assign table_high_holding_o = thh_reg;
   assign irq_pend_o = pend_reg;
   assign irq_ack_o = ack_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_reset_vec;
      @(posedge clock_i) $rose(reset_n_i) |-> pc_reg == RESET_VECTOR;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector"); // see R1
   property p_ext_vec;
      @(posedge clock_i) disable iff (!reset_n_i) take.ext |=> pc_reg == EXT_VECTOR;
   endproperty
   a_ext_vec: assert property (p_ext_vec) else $error("ext vector wrong"); // see R2
   property p_fall;
      @(posedge clock_i) disable iff (!reset_n_i)
         (edge_select_control_i == EDGE_FALL && ext_d_reg && !ext_pin_i && irq_en_i.ext) |=> pend_reg.ext;
   endproperty
   a_fall: assert property (p_fall) else $error("falling edge missed"); // see R3
   property p_tmr0;
      @(posedge clock_i) disable iff (!reset_n_i) take.tmr0 |=> pc_reg == TMR0_VECTOR;
   endproperty
   a_tmr0: assert property (p_tmr0) else $error("timer vector wrong"); // see R4
   property p_adc;
      @(posedge clock_i) disable iff (!reset_n_i) take.adc |=> pc_reg == ADC_VECTOR;
   endproperty
   a_adc: assert property (p_adc) else $error("adc vector wrong"); // see R5
   property p_tb;
      @(posedge clock_i) disable iff (!reset_n_i) take.tb |=> pc_reg == TB_VECTOR;
   endproperty
   a_tb: assert property (p_tb) else $error("time base vector wrong"); // see R6
   property p_last;
      @(posedge clock_i) disable iff (!reset_n_i)
         (state_reg == ST_TBL && tbl_is_last_reg) |=> paddr_reg[10:8] == LAST_PAGE;
   endproperty
   a_last: assert property (p_last) else $error("last page not forced"); // see R9
   property p_cur;
      @(posedge clock_i) disable iff (!reset_n_i)
         (state_reg == ST_TBL && !tbl_is_last_reg) |=> paddr_reg == {$past(pc_reg[10:8]), $past(tbl_ptr_reg)};
   endproperty
   a_cur: assert property (p_cur) else $error("current page address wrong"); // see R8
   property p_two;
      @(posedge clock_i) disable iff (!reset_n_i) $rose(tbl_busy_o) |-> tbl_busy_o ##1 tbl_busy_o ##1 !tbl_busy_o;
   endproperty
   a_two: assert property (p_two) else $error("table read not two cycles"); // see R13
   property p_full;
      @(posedge clock_i) disable iff (!reset_n_i) stack_full |-> !(|take);
   endproperty
   a_full: assert property (p_full) else $error("ack while stack full"); // see R23
   c_tbl_last: cover property (@(posedge clock_i) disable iff (!reset_n_i) state_reg == ST_TBL && tbl_is_last_reg);
   c_irq: cover property (@(posedge clock_i) disable iff (!reset_n_i) ack_reg);
   c_full: cover property (@(posedge clock_i) disable iff (!reset_n_i) stack_full && |pend_reg);
endmodule // ptr_unit

// [sim/ptr_prog_mem.sv]
`timescale 1ns/10ps
// ----------------------------------------
// program memory model for the fetch port
// ----------------------------------------
module ptr_prog_mem
(
   // fetch address from the unit
   input wire logic [10:0] prog_addr_i,
   // word back, combinational like the unit expects
   output logic [14:0] prog_data_o
);
   // page bits fold into the word so a wrong page gives a wrong byte
   assign prog_data_o = {prog_addr_i[6:0] ^ 7'h2A, prog_addr_i[7:0] ^ {prog_addr_i[10:8], 5'h13}};
endmodule // ptr_prog_mem

// [sim/ptr_unit_tb_top.sv]
`timescale 1ns/10ps
module ptr_unit_tb_top
   import ptr_pkg::*;
;
   typedef struct packed {logic [2:0] k; logic [14:0] v;} ptr_note_t;
   logic clock_i, reset_n_i, step_i, tc, tl, rt, cl, ple, ext_pin, busy, ack;
   logic [10:0] pcl, pc, paddr;
   logic [7:0] dest, rdata;
   logic [1:0] esel;
   logic [3:0] src;
   logic [6:0] hold;
   logic [14:0] pdata, w, got;
   logic [31:0] rnd;
   logic [10:0] vtab [4];
   logic [1:0] codes [4];
   logic [3:0] st, want;
   ptr_irq_t en, pend;
   ptr_dacc_t dacc;
   ptr_note_t q[$];
   ptr_note_t nt;
   int n_fail, checks, i, j;

   ptr_unit dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .step_i(step_i), .tbl_current_i(tc),
      .tbl_last_i(tl), .tbl_dest_i(dest), .ret_i(rt), .call_i(cl), .pc_load_i(pcl), .pc_load_en_i(ple),
      .prog_data_i(pdata), .ext_pin_i(ext_pin), .edge_select_control_i(esel), .irq_en_i(en),
      .tmr0_ovf_i(src[0]), .tmr1_ovf_i(src[1]), .adc_done_i(src[2]), .tb_ovf_i(src[3]), .dacc_i(dacc),
      .pc_o(pc), .prog_addr_o(paddr), .tbl_busy_o(busy), .rdata_o(rdata), .table_high_holding_o(hold),
      .irq_pend_o(pend), .irq_ack_o(ack));
   ptr_prog_mem mem (.prog_addr_i(paddr), .prog_data_o(pdata));

   // --------------------------------
   // helpers
   // --------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction
   function automatic logic [14:0] word_of(input logic [10:0] a);
      return {a[6:0] ^ 7'h2A, a[7:0] ^ {a[10:8], 5'h13}};
   endfunction

   // free running clock, 50 ns period
   initial
   begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   // every queued note is compared at the next falling edge, when outputs have settled
   always @(negedge clock_i)
   begin
      while (q.size() > 0)
      begin
         nt = q.pop_front();
         case (nt.k)
            3'h0: got = {4'h0, pc};
            3'h1: got = {4'h0, paddr};
            3'h2: got = {7'h0, rdata};
            3'h3: got = {8'h0, hold};
            3'h4: got = {14'h0, busy};
            default: got = {10'h0, pend};
         endcase
         checks++;
         if (got !== nt.v)
            $display("mismatch at %0t: kind %0d got %h want %h", $time, nt.k, got, nt.v);
         if (got !== nt.v)
            n_fail++;
      end
   end

   task automatic note(input logic [2:0] k, input logic [14:0] v);
      q.push_back({k, v});
   endtask
   task automatic wrap_up;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // flags are wr, rd, bit set, bit clear
   task automatic acc(input logic [3:0] f, input logic [2:0] b, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      dacc <= {f, b, a, d};
      @(posedge clock_i);
      dacc <= '0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      acc(4'b0100, 3'h0, a, 8'h00);
      @(posedge clock_i);
      note(3'h2, {7'h0, e});
   endtask
   task automatic stepop(input logic r, input logic c);
      @(posedge clock_i);
      step_i <= 1'b1;
      rt <= r;
      cl <= c;
      @(posedge clock_i);
      step_i <= 1'b0;
      rt <= 1'b0;
      cl <= 1'b0;
   endtask
   task automatic pulse(input logic [3:0] s);
      @(posedge clock_i);
      src <= s;
      @(posedge clock_i);
      src <= 4'h0;
   endtask
   // fixed window of single steps: an interrupt is only taken on a step,
   // so stepping stops as soon as it shows and pc keeps the vector
   task automatic wait_ack(input logic wnt);
      logic seen;
      seen = 1'b0;
      for (int k = 0; k < 8 && !seen; k++)
      begin
         @(posedge clock_i);
         step_i <= 1'b1;
         @(posedge clock_i);
         step_i <= 1'b0;
         @(negedge clock_i);
         if (ack === 1'b1)
            seen = 1'b1;
      end
      checks++;
      if (seen !== wnt)
      begin
         n_fail++;
         $display("mismatch at %0t: acknowledge %b", $time, seen);
         if (wnt)
            wrap_up();
      end
   endtask
   task automatic tbl(input logic last, input logic [7:0] p, input logic [10:0] a);
      w = word_of(a);
      acc(4'b1000, 3'h0, ADDR_TBLP, p);
      @(posedge clock_i);
      step_i <= 1'b1;
      tc <= ~last;
      tl <= last;
      @(posedge clock_i);
      step_i <= 1'b0;
      tc <= 1'b0;
      tl <= 1'b0;
      note(3'h4, 15'h1);
      @(posedge clock_i);
      note(3'h1, {4'h0, a});
      for (j = 0; j < 6 && busy !== 1'b0; j++)
         @(negedge clock_i);
      if (busy !== 1'b0)
      begin
         n_fail++;
         $display("mismatch at %0t: table read never finished", $time);
         wrap_up();
      end
      @(posedge clock_i);
      note(3'h3, {8'h0, w[14:8]});
      rd_chk(dest, w[7:0]);
      acc(4'b1000, 3'h0, ADDR_THH, 8'hFF);
      acc(4'b0010, 3'h7, ADDR_THH, 8'h00);
      rd_chk(ADDR_THH, {1'b0, w[14:8]});
   endtask

   // --------------------------------
   // main sequence
   // --------------------------------
   initial
   begin
      {reset_n_i, step_i, tc, tl, rt, cl, ple, ext_pin, esel, src, pcl} = '0;
      dacc = '0;
      dest = 8'h60;
      en = 5'h1F;
      rnd = 32'h4C14;
      vtab = '{TMR0_VECTOR, TMR1_VECTOR, ADC_VECTOR, TB_VECTOR};
      codes = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH, 2'h0};
      st = 4'b0010;
      want = 4'b0111;
      repeat (6) @(posedge clock_i);
      reset_n_i <= 1'b1;
      note(3'h0, {4'h0, RESET_VECTOR});
      rnd = lfsr(rnd);
      acc(4'b1000, 3'h0, GP_BASE, rnd[7:0]);
      acc(4'b1000, 3'h0, 8'h9F, ~rnd[7:0]);
      rd_chk(GP_BASE, rnd[7:0]);
      rd_chk(8'h9F, ~rnd[7:0]);
      acc(4'b1000, 3'h0, SFR_END, 8'hA5);
      rd_chk(SFR_END, 8'h00);
      acc(4'b1000, 3'h0, ADDR_MP0, 8'h45);
      acc(4'b1000, 3'h0, ADDR_IND0, 8'h3C);
      rd_chk(8'h45, 8'h3C);
      acc(4'b0010, 3'h6, 8'h45, 8'h00);
      acc(4'b0001, 3'h2, 8'h45, 8'h00);
      rd_chk(8'h45, 8'h78);
      @(posedge clock_i);
      step_i <= 1'b1;
      ple <= 1'b1;
      pcl <= 11'h5A0;
      @(posedge clock_i);
      step_i <= 1'b0;
      ple <= 1'b0;
      note(3'h0, 15'h05A0);
      rnd = lfsr(rnd);
      tbl(1'b0, rnd[7:0], {3'h5, rnd[7:0]});
      tbl(1'b1, rnd[15:8], {LAST_PAGE, rnd[15:8]});
      for (i = 0; i < 4; i++)
      begin
         @(posedge clock_i);
         esel <= 2'h0;
         ext_pin <= st[i];
         repeat (2) @(posedge clock_i);
         esel <= codes[i];
         repeat (2) @(posedge clock_i);
         ext_pin <= ~st[i];
         wait_ack(want[i]);
         if (want[i])
            note(3'h0, {4'h0, EXT_VECTOR});
         if (want[i])
            stepop(1'b1, 1'b0);
      end
      for (i = 0; i < 4; i++)
      begin
         pulse(4'h1 << i);
         wait_ack(1'b1);
         note(3'h0, {4'h0, vtab[i]});
         stepop(1'b1, 1'b0);
      end
      for (i = 0; i < STACK_DEPTH; i++)
         stepop(1'b0, 1'b1);
      pulse(4'h8);
      wait_ack(1'b0);
      note(3'h5, 15'h01);
      stepop(1'b1, 1'b0);
      wait_ack(1'b1);
      note(3'h0, {4'h0, TB_VECTOR});
      // free a level so that only the disabled enable can refuse
      stepop(1'b1, 1'b0);
      en <= '0;
      pulse(4'h1);
      wait_ack(1'b0);
      repeat (2) @(posedge clock_i);
      wrap_up();
   end
endmodule // ptr_unit_tb_top
